/* File: hdl/asp_defs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 40 MHz system clock
// Notes:   Definitions only
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ==========================================
// Register offsets
`define ASP_OFS_CTRL_A      8'h08
`define ASP_OFS_CTRL_B      8'h09
`define ASP_OFS_DATA_OFS    8'h0a
`define ASP_OFS_FLAGS       8'h0b
`define ASP_OFS_FILT        8'h0c

// ==========================================
// Field positions
`define ASP_A_BCLK_DIR      7
`define ASP_A_WCLK_DIR      6
`define ASP_A_DOUT_HIZ      5
`define ASP_A_WMASK         8'hf4
`define ASP_B_MODE          7:6
`define ASP_B_WLEN          5:4
`define ASP_B_RATE          3
`define ASP_B_DAC_RS        2
`define ASP_B_ADC_RS        1
`define ASP_B_RS_MUTE       0
`define ASP_F_OVF           7:4
`define ASP_F_PLLR          3:0
`define ASP_T_HPF_L         7:6
`define ASP_T_HPF_R         5:4
`define ASP_T_FX_L          3
`define ASP_T_DEEM_L        2
`define ASP_T_FX_R          1
`define ASP_T_DEEM_R        0

// ==========================================
// Reset values
`define ASP_RST_PLLR        4'h1

// ==========================================
// Timing
`define ASP_CLK_NS          25
`define ASP_BCLK_HALF_NS    100
`define ASP_BCLK_HALF_CYC   ((`ASP_BCLK_HALF_NS) / (`ASP_CLK_NS))
`define ASP_MUTE_NS         1000
`define ASP_MUTE_CYC        ((`ASP_MUTE_NS) / (`ASP_CLK_NS))
`define ASP_FRAME_256       9'd256

`endif

/* File: hdl/asp_pkg.sv */
// Purpose: Types shared by the audio serial port
// Assumes: Constants live in asp_defs.svh
// Notes:   State of the core is one packed struct
package asp_pkg;

   // ==========================================
   // Frame formats
   typedef enum logic [1:0] {
      ASP_FMT_I2S = 2'b00,
      ASP_FMT_DSP = 2'b01,
      ASP_FMT_RJ  = 2'b10,
      ASP_FMT_LJ  = 2'b11
   } asp_fmt_t;

   typedef struct packed {
      logic [31:0] left;
      logic [31:0] right;
   } asp_pair_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } asp_reg_req_t;

   typedef struct packed {
      logic       hit;
      logic [5:0] idx;
   } asp_slot_t;

   typedef struct packed {
      logic [2:0]       bclk_sync;
      logic [2:0]       wclk_sync;
      logic [2:0]       din_sync;
      logic             bclk_lvl;
      logic             wclk_lvl;
      logic             din_lvl;
      logic             wclk_prev;
      logic [7:0]       div_cnt;
      logic             bclk_gen;
      logic             wclk_gen;
      logic [8:0]       pos;
      logic [8:0]       flen;
      logic [7:0]       ctrl_a;
      logic [7:0]       ctrl_b;
      logic [7:0]       ofs;
      logic [3:0]       flags;
      logic [3:0]       pllr;
      logic [7:0]       filt;
      logic [7:0]       rdata;
      asp_pair_t        tx_hold;
      logic             tx_full;
      asp_pair_t        tx_cur;
      logic             dout;
      logic             dout_on;
      logic [31:0]      rx_l;
      logic [31:0]      rx_r;
      asp_pair_t        buf0;
      asp_pair_t        buf1;
      logic [1:0]       buf_cnt;
      logic [15:0]      clk_cnt;
      logic [15:0]      fperiod;
      logic [1:0][15:0] ref_ph;
      logic [1:0]       ref_ok;
      logic [1:0][7:0]  mute_cnt;
      logic [1:0]       resync;
   } asp_state_t;

endpackage

/* File: hdl/asp_core.sv */
// Purpose: Audio serial port framing, configuration registers and status flags
// Assumes: Link pins are asynchronous to clk; register port is on clk
// Notes:   Bit clock sampled by clk, so it must stay well below clk / 6
//
// What this block does
// (RQ1) Two-bit mode field picks I2S, DSP, right- or left-justified framing.
// (RQ2) Two-bit word length field picks 16, 20, 24 or 32 bits.
// (RQ3) Bit clock rate bit matters only while the bit clock is driven out.
// (RQ4) Rate bit clear uses continuous timing; set gives 256 bit clocks per frame.
// (RQ5) DAC re-sync bit realigns DAC when its delay drifts past a quarter sample.
// (RQ6) ADC re-sync bit realigns ADC when its delay drifts past a quarter sample.
// (RQ7) Re-sync mute bit soft-mutes the realigned channel during re-sync.
// (RQ8) Eight-bit offset sets bit clocks from frame start to first data bit.
// (RQ9) In DSP format the offset counts from word clock rising edge.
// (RQ10) Software keeps offset at most 17, or 16 in DSP, under continuous timing.
// (RQ11) Software keeps offset at most 242, or 241 in DSP, under 256-clock framing.
// (RQ12) Four overflow flags latch at one and stay set until the flag register is read.
// (RQ13) Reading the flag register clears the flags it returned.
// (RQ14) Four-bit PLL R field shares the flag register; zero means 16, resets to 1.
// (RQ15) Left ADC high-pass field: off or one of three corners.
// (RQ16) Right ADC high-pass field: same choices, independent.
// (RQ17) Per-channel bits insert or bypass DAC effects filters.
// (RQ18) Per-channel bits insert or bypass DAC de-emphasis filters.
// (RQ19) Bit clock direction bit: input as slave at 0, driven as master at 1.
// (RQ20) Word clock direction bit: input as slave at 0, driven as master at 1.
// (RQ21) Master continuous timing sends just enough bit clocks for two slots.
`timescale 1ns/1ps
`include "asp_defs.svh"

module asp_core #(
   parameter logic [7:0] BCLK_HALF_CYC = 8'(`ASP_BCLK_HALF_CYC),
   parameter logic [7:0] MUTE_CYC      = 8'(`ASP_MUTE_CYC)
) (
   input  logic                 clk,
   input  logic                 sys_rst,
   input  asp_pkg::asp_reg_req_t reg_req,
   output logic [7:0]           reg_rdata,
   input  logic                 bclk_in,
   output logic                 bclk_out,
   output logic                 bclk_oe_n,
   input  logic                 wclk_in,
   output logic                 wclk_out,
   output logic                 wclk_oe_n,
   input  logic                 din,
   output logic                 dout,
   output logic                 dout_oe_n,
   input  asp_pkg::asp_pair_t   adc_pair,
   input  logic                 adc_valid,
   output logic                 adc_ready,
   output asp_pkg::asp_pair_t   dac_pair,
   output logic                 dac_valid,
   input  logic                 dac_ready,
   output logic                 dac_buf_ready,
   input  logic [3:0]           conv_ovf,
   input  logic [1:0]           conv_tick,
   output logic [1:0]           conv_resync,
   output logic [1:0]           conv_mute,
   output logic [4:0]           pll_r_value,
   output logic [1:0]           hpf_left,
   output logic [1:0]           hpf_right,
   output logic [1:0]           effects_en,
   output logic [1:0]           deemph_en
);
   import asp_pkg::*;

   // ==========================================
   // Decoding helpers
   function automatic logic [5:0] wl_bits(input logic [1:0] code);
      case (code)
         2'b00:   wl_bits = 6'd16;
         2'b01:   wl_bits = 6'd20;
         2'b10:   wl_bits = 6'd24;
         default: wl_bits = 6'd32;
      endcase
   endfunction

   function automatic asp_slot_t slot_of(input logic [8:0] p, input logic [8:0] st,
                                         input logic [5:0] w);
      logic [8:0] d;
      d = p - st;
      slot_of.hit = (p >= st) && (d < {3'b000, w});
      slot_of.idx = w - 6'd1 - d[5:0];
   endfunction

   asp_state_t s;
   asp_state_t next_s;
   asp_fmt_t   fmt;
   logic       bclk_m;
   logic       wclk_m;
   logic [5:0] wl;
   logic [8:0] flen;
   logic [8:0] half;
   logic [8:0] ls;
   logic [8:0] rs;
   logic [8:0] up;
   logic [8:0] pos_n;
   logic       div_hit;
   logic       rise;
   logic       fall;
   logic       w;
   logic       fe;
   asp_slot_t  tl;
   asp_slot_t  tr;
   asp_slot_t  rl;
   asp_slot_t  rr;
   logic       push;
   logic       drop;
   logic       rd_flags;
   logic [1:0] c;
   logic [15:0] dph;
   asp_pair_t  tx;

   // ==========================================
   // Frame geometry
   assign fmt    = asp_fmt_t'(s.ctrl_b[`ASP_B_MODE]); // RQ1
   assign bclk_m = s.ctrl_a[`ASP_A_BCLK_DIR];
   assign wclk_m = s.ctrl_a[`ASP_A_WCLK_DIR];
   assign wl     = wl_bits(s.ctrl_b[`ASP_B_WLEN]); // RQ2
   // Rate bit is looked at only when the bit clock is ours
   assign flen   = !bclk_m ? s.flen :                                // RQ3
                   (s.ctrl_b[`ASP_B_RATE] ? `ASP_FRAME_256 :         // RQ4
                    {2'b00, wl, 1'b0});                              // RQ21
   assign half   = {1'b0, flen[8:1]};
   // I2S data trails its word clock edge by one bit clock
   assign ls     = {1'b0, s.ofs} + ((fmt == ASP_FMT_I2S) ? 9'd1 : 9'd0)      // RQ8
                   + ((fmt == ASP_FMT_RJ) ? half - {3'b000, wl} : 9'd0);
   assign rs     = ls + ((fmt == ASP_FMT_DSP) ? {3'b000, wl} : half);
   assign up     = (s.pos + 9'd1 == flen) ? 9'd0 : s.pos + 9'd1;

   // ==========================================
   // Bit clock events
   assign div_hit = s.div_cnt == BCLK_HALF_CYC - 8'd1;
   assign rise = bclk_m ? (div_hit & ~s.bclk_gen)
                        : (s.bclk_sync[1] == s.bclk_sync[2]) & s.bclk_sync[2] & ~s.bclk_lvl;
   assign fall = bclk_m ? (div_hit & s.bclk_gen)
                        : (s.bclk_sync[1] == s.bclk_sync[2]) & ~s.bclk_sync[2] & s.bclk_lvl;
   assign w    = wclk_m ? s.wclk_gen : s.wclk_lvl;
   // I2S frames open on the falling word clock edge, all others on rising
   assign fe   = (fmt == ASP_FMT_I2S) ? (s.wclk_prev & ~w) : (~s.wclk_prev & w); // RQ9
   // Free-running in slave so a measured length is never capped by the last one
   assign pos_n = fe ? 9'd0 : (bclk_m ? up : s.pos + 9'd1);
   assign tl = slot_of(up, ls, wl);
   assign tr = slot_of(up, rs, wl);
   assign rl = slot_of(pos_n, ls, wl);
   assign rr = slot_of(pos_n, rs, wl);
   assign push = rise & rr.hit & (rr.idx == 6'd0);
   assign drop = push & (s.buf_cnt == 2'd2) & ~dac_ready;
   assign rd_flags = reg_req.rd & (reg_req.addr == `ASP_OFS_FLAGS);

   always_comb begin
      next_s = s;
      c = s.buf_cnt;
      dph = 16'h0000;
      tx = s.tx_cur;
      // Synchronisers; a level counts once the second and third stages agree
      next_s.bclk_sync = {s.bclk_sync[1:0], bclk_in};
      next_s.wclk_sync = {s.wclk_sync[1:0], wclk_in};
      next_s.din_sync  = {s.din_sync[1:0], din};
      if (s.bclk_sync[1] == s.bclk_sync[2])
         next_s.bclk_lvl = s.bclk_sync[2];
      if (s.wclk_sync[1] == s.wclk_sync[2])
         next_s.wclk_lvl = s.wclk_sync[2];
      if (s.din_sync[1] == s.din_sync[2])
         next_s.din_lvl = s.din_sync[2];

      // ==========================================
      // Register port
      if (reg_req.wr) begin
         case (reg_req.addr)
            `ASP_OFS_CTRL_A:   next_s.ctrl_a = reg_req.wdata & `ASP_A_WMASK;
            `ASP_OFS_CTRL_B:   next_s.ctrl_b = reg_req.wdata;
            `ASP_OFS_DATA_OFS: next_s.ofs = reg_req.wdata; // RQ8
            `ASP_OFS_FLAGS:    next_s.pllr = reg_req.wdata[`ASP_F_PLLR]; // RQ14
            `ASP_OFS_FILT:     next_s.filt = reg_req.wdata;
            default: ;
         endcase
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            `ASP_OFS_CTRL_A:   next_s.rdata = s.ctrl_a;
            `ASP_OFS_CTRL_B:   next_s.rdata = s.ctrl_b;
            `ASP_OFS_DATA_OFS: next_s.rdata = s.ofs;
            `ASP_OFS_FLAGS:    next_s.rdata = {s.flags, s.pllr};
            `ASP_OFS_FILT:     next_s.rdata = s.filt;
            default:           next_s.rdata = 8'h00;
         endcase
      end
      // Sticky flags; a new overflow in the clearing cycle is kept
      next_s.flags = (s.flags & ~{4{rd_flags}})                         // RQ13
                     | conv_ovf | {2'b00, drop, drop};                  // RQ12

      // ==========================================
      // Master clock generation
      next_s.div_cnt = div_hit ? 8'h00 : s.div_cnt + 8'h01;
      if (div_hit)
         next_s.bclk_gen = ~s.bclk_gen;
      if (fall) begin
         case (fmt)
            ASP_FMT_I2S: next_s.wclk_gen = up >= half;
            ASP_FMT_DSP: next_s.wclk_gen = up == 9'd0;
            default:     next_s.wclk_gen = up < half;
         endcase
         // New word taken at the fall before position 0, so a zero offset sends it whole
         if (up == 9'd0) begin
            tx = s.tx_full ? s.tx_hold : '0;
            next_s.tx_cur = tx;
            next_s.tx_full = 1'b0;
         end
         // Launch on the fall for the far end's next rising edge
         next_s.dout = tl.hit ? tx.left[tl.idx[4:0]]
                     : (tr.hit ? tx.right[tr.idx[4:0]] : 1'b0);
         next_s.dout_on = tl.hit | tr.hit | ~s.ctrl_a[`ASP_A_DOUT_HIZ];
      end

      // ==========================================
      // Frame tracking and capture
      next_s.clk_cnt = (s.clk_cnt == 16'hffff) ? s.clk_cnt : s.clk_cnt + 16'h0001;
      if (rise) begin
         next_s.wclk_prev = w;
         next_s.pos = pos_n;
         if (fe)
            next_s.flen = s.pos + 9'd1;
         if (rl.hit)
            next_s.rx_l[rl.idx[4:0]] = s.din_lvl;
         if (rr.hit)
            next_s.rx_r[rr.idx[4:0]] = s.din_lvl;
         if (pos_n == 9'd0) begin
            next_s.fperiod = s.clk_cnt;
            next_s.clk_cnt = 16'h0000;
         end
      end
      if (adc_valid && !s.tx_full) begin
         next_s.tx_hold = adc_pair;
         next_s.tx_full = 1'b1;
      end

      // ==========================================
      // Receive buffer, head entry drives the outputs
      if (dac_ready && c != 2'd0) begin
         next_s.buf0 = s.buf1;
         c = c - 2'd1;
      end
      if (push && c != 2'd2) begin
         if (c == 2'd0)
            next_s.buf0 = '{left: s.rx_l, right: next_s.rx_r};
         else
            next_s.buf1 = '{left: s.rx_l, right: next_s.rx_r};
         c = c + 2'd1;
      end
      next_s.buf_cnt = c;

      // ==========================================
      // Converter re-sync, index 0 is the DAC, 1 the ADC
      next_s.resync = 2'b00;
      for (int k = 0; k < 2; k++) begin
         if (s.mute_cnt[k] != 8'h00)
            next_s.mute_cnt[k] = s.mute_cnt[k] - 8'h01;
         if (!s.ctrl_b[`ASP_B_DAC_RS - k]) begin
            next_s.ref_ok[k] = 1'b0;
         end else if (conv_tick[k]) begin
            dph = (s.clk_cnt > s.ref_ph[k]) ? s.clk_cnt - s.ref_ph[k]
                                            : s.ref_ph[k] - s.clk_cnt;
            if (!s.ref_ok[k]) begin
               next_s.ref_ph[k] = s.clk_cnt;
               next_s.ref_ok[k] = 1'b1;
            end else if (dph > {2'b00, s.fperiod[15:2]}) begin // RQ5 RQ6
               next_s.ref_ph[k] = s.clk_cnt;
               next_s.resync[k] = 1'b1;
               if (s.ctrl_b[`ASP_B_RS_MUTE])
                  next_s.mute_cnt[k] = MUTE_CYC; // RQ7
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s      <= '0;
         s.pllr <= `ASP_RST_PLLR; // RQ14
      end else begin
         s <= next_s;
      end
   end

   // ==========================================
   // Outputs
   assign reg_rdata     = s.rdata;
   assign bclk_out      = s.bclk_gen;
   assign bclk_oe_n     = ~bclk_m; // RQ19
   assign wclk_out      = s.wclk_gen;
   assign wclk_oe_n     = ~wclk_m; // RQ20
   assign dout          = s.dout;
   assign dout_oe_n     = ~s.dout_on;
   assign adc_ready     = ~s.tx_full;
   assign dac_pair      = s.buf0;
   assign dac_valid     = s.buf_cnt != 2'd0;
   assign dac_buf_ready = s.buf_cnt != 2'd2;
   assign conv_resync   = s.resync;
   assign conv_mute     = {s.mute_cnt[1] != 8'h00, s.mute_cnt[0] != 8'h00}; // RQ7
   assign pll_r_value   = (s.pllr == 4'h0) ? 5'd16 : {1'b0, s.pllr}; // RQ14
   assign hpf_left      = s.filt[`ASP_T_HPF_L]; // RQ15
   assign hpf_right     = s.filt[`ASP_T_HPF_R]; // RQ16
   assign effects_en    = {s.filt[`ASP_T_FX_L], s.filt[`ASP_T_FX_R]}; // RQ17
   assign deemph_en     = {s.filt[`ASP_T_DEEM_L], s.filt[`ASP_T_DEEM_R]}; // RQ18

endmodule // asp_core

/* File: tb/aspc_asserts.sv */
// Purpose: Port assertions for the audio serial port core
// Assumes: Bit clock half period left at its default of four clk cycles
// Notes:   Bound into every asp_core instance
`timescale 1ns/1ps
module aspc_asserts (
   input logic                  clk,
   input logic                  sys_rst,
   input asp_pkg::asp_reg_req_t reg_req,
   input logic [7:0]            reg_rdata,
   input logic                  bclk_out,
   input logic                  bclk_oe_n,
   input logic                  wclk_oe_n,
   input logic [3:0]            conv_ovf,
   input logic [4:0]            pll_r_value,
   input logic [1:0]            hpf_left,
   input logic [1:0]            hpf_right,
   input logic [1:0]            effects_en,
   input logic [1:0]            deemph_en
);
   import asp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ========================================
   // Register access and master bit clock timing
   sequence rd_at(logic [7:0] a);
      reg_req.rd && reg_req.addr == a;
   endsequence
   sequence wr_at(logic [7:0] a);
      reg_req.wr && reg_req.addr == a;
   endsequence
   a_unmapped_zero:
      assert property (rd_at(8'h0d) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_ovf_sticky:
      assert property (conv_ovf[3] ##1 rd_at(8'h0b) |=> reg_rdata[7]) else $error("flag lost");
   a_ovf_read_clear:
      assert property (rd_at(8'h0b) ##0 conv_ovf == 4'h0 ##1 !reg_req.rd && conv_ovf == 4'h0
         ##1 rd_at(8'h0b) ##0 conv_ovf == 4'h0 |=> reg_rdata[7:4] == 4'h0)
         else $error("flags not cleared by read");
   a_pll_r_map:
      assert property (rd_at(8'h0b) |=> pll_r_value ==
         ((reg_rdata[3:0] == 4'h0) ? 5'h10 : {1'b0, reg_rdata[3:0]})) else $error("pll r wrong");
   a_bclk_dir_bit:
      assert property (wr_at(8'h08) |=> bclk_oe_n == !$past(reg_req.wdata[7]))
         else $error("bit clock direction wrong");
   a_wclk_dir_bit:
      assert property (wr_at(8'h08) |=> wclk_oe_n == !$past(reg_req.wdata[6]))
         else $error("word clock direction wrong");
   a_hpf_codes:
      assert property (wr_at(8'h0c) |=> {hpf_left, hpf_right} == $past(reg_req.wdata[7:4]))
         else $error("high-pass codes wrong");
   a_filter_enables:
      assert property (wr_at(8'h0c) |=> {effects_en, deemph_en} == {$past(reg_req.wdata[3]),
         $past(reg_req.wdata[1]), $past(reg_req.wdata[2]), $past(reg_req.wdata[0])})
         else $error("filter enables wrong");
   a_master_bclk_half:
      assert property ($rose(bclk_out) && !bclk_oe_n |-> bclk_out[*4] ##1 !bclk_out)
         else $error("bit clock half period wrong");
endmodule // aspc_asserts

bind asp_core aspc_asserts u_asserts (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n), .wclk_oe_n(wclk_oe_n),
   .conv_ovf(conv_ovf), .pll_r_value(pll_r_value), .hpf_left(hpf_left),
   .hpf_right(hpf_right), .effects_en(effects_en), .deemph_en(deemph_en));

/* File: tb/aspc_host_port.sv */
// Purpose: Host audio port leading the link in slave-mode tests
// Assumes: Left-justified, 16-bit slots, zero offset
// Notes:   Clocks stand still between runs; data line wanders
`timescale 1ns/1ps
module aspc_host_port (
   input  logic        run,
   input  logic [31:0] word,
   output logic        bclk,
   output logic        wclk,
   output logic        din
);
   int p;
   initial begin
      bclk = 1'b0;
      wclk = 1'b0;
      din = 1'b0;
      forever begin
         // Released line must not look like held data
         while (!run) #100 din = ~din;
         for (p = 0; p < 32; p++) begin
            wclk = (p < 16);
            din = word[31 - p];
            #100 bclk = 1'b1;
            #100 bclk = 1'b0;
         end
      end
   end
endmodule // aspc_host_port

/* File: tb/audio_serial_port_config_bench.sv */
// Purpose: Self-checking bench for the audio serial port core
// Assumes: Default bit clock and mute counts
// Notes:   Register, serial receive, buffer and master framing tests
`timescale 1ns/1ps
`include "asp_defs.svh"
module audio_serial_port_config_bench;
   import asp_pkg::*;
   logic         clk, sys_rst, h_run, h_bclk, h_wclk, h_din;
   logic         bclk_out, bclk_oe_n, wclk_out, wclk_oe_n, dac_valid, dac_ready, dac_buf_ready;
   logic [7:0]   reg_rdata, d;
   logic [3:0]   conv_ovf;
   logic [4:0]   pll_r_value;
   logic [1:0]   hpf_left, hpf_right, effects_en, deemph_en;
   logic [1:0]   tick, conv_resync, conv_mute;
   logic         dout, dout_oe_n;
   logic [31:0]  q;
   asp_reg_req_t reg_req;
   asp_pair_t    dac_pair;
   int           err_count, tests_run, i, n;
   logic [7:0]   cfg[5] = '{8'hc0, 8'h50, 8'h60, 8'hb0, 8'h08};
   int           len[5] = '{32, 40, 48, 64, 256};

   asp_core DUT (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .bclk_in(bclk_oe_n ? h_bclk : bclk_out), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n),
      .wclk_in(wclk_oe_n ? h_wclk : wclk_out), .wclk_out(wclk_out), .wclk_oe_n(wclk_oe_n),
      .din(h_din), .dout(dout), .dout_oe_n(dout_oe_n), .adc_pair(64'h0000_5a5a_0000_c3c3),
      .adc_valid(1'b1), .adc_ready(), .dac_pair(dac_pair), .dac_valid(dac_valid),
      .dac_ready(dac_ready), .dac_buf_ready(dac_buf_ready), .conv_ovf(conv_ovf),
      .conv_tick(tick), .conv_resync(conv_resync), .conv_mute(conv_mute),
      .pll_r_value(pll_r_value), .hpf_left(hpf_left),
      .hpf_right(hpf_right), .effects_en(effects_en), .deemph_en(deemph_en));
   aspc_host_port u_host (.run(h_run), .word(32'h1234_abcd), .bclk(h_bclk), .wclk(h_wclk),
      .din(h_din));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ========================================
   // Access and compare tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk) reg_req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(negedge clk) reg_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [3:0] o, output logic [7:0] v);
      @(negedge clk) reg_req.addr = a;
      reg_req.rd = 1'b1;
      conv_ovf = o;
      @(negedge clk) reg_req.rd = 1'b0;
      conv_ovf = 4'h0;
      v = reg_rdata;
   endtask
   task automatic chk(input string w, input logic [63:0] e, input logic [63:0] s);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, 4'h0, v);
      chk($sformatf("reg %h", a), {56'h0, e}, {56'h0, v});
   endtask
   task automatic pulse(input int g);
      repeat (g) @(negedge clk);
      tick = 2'b11;
      @(negedge clk) tick = 2'b00;
   endtask
   task automatic frame_len(output int c, output logic [31:0] b);
      int k, r;
      logic pw, pb;
      c = 0;
      b = '0;
      r = 0;
      pw = wclk_out;
      pb = bclk_out;
      for (k = 0; k < 6000 && r < 2; k++) begin
         @(negedge clk);
         if (wclk_out && !pw) r++;
         if (r == 1 && bclk_out && !pb) begin
            c++;
            b = {b[30:0], dout};
         end
         pw = wclk_out;
         pb = bclk_out;
      end
      if (r < 2) begin
         err_count++;
         $display("MISMATCH frame start expected 2 seen %0d", r);
         complete_run();
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ========================================
   // Test sequence
   initial begin
      {sys_rst, dac_ready, h_run, reg_req, conv_ovf, tick, err_count, tests_run} = '0;
      sys_rst = 1'b1;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      for (i = 0; i < 6; i++) chk_rd(8'h08 + 8'(i), (i == 3) ? 8'h01 : 8'h00);
      chk("pll", 64'd1, 64'(pll_r_value));
      $display("reset test done");
      wr(8'h08, 8'h3f);
      chk_rd(8'h08, 8'h34);
      wr(8'h09, 8'hff);
      chk_rd(8'h09, 8'hff);
      wr(8'h0a, 8'hff);
      chk_rd(8'h0a, 8'hff);
      wr(8'h0b, 8'hf0);
      chk_rd(8'h0b, 8'h00);
      chk("pll", 64'd16, 64'(pll_r_value));
      wr(8'h0d, 8'h55);
      chk_rd(8'h0d, 8'h00);
      for (i = 0; i < 4; i++) begin
         d = {i[1:0], ~i[1:0], i[0], i[1], ~i[0], ~i[1]};
         wr(8'h0c, d);
         chk_rd(8'h0c, d);
         chk("filt", {d[7:4], d[3], d[1], d[2], d[0]},
            {hpf_left, hpf_right, effects_en, deemph_en});
      end
      $display("register test done");
      wr(8'h0b, 8'h01);
      @(negedge clk) conv_ovf = 4'b1010;
      chk_rd(8'h0b, 8'ha1);
      chk_rd(8'h0b, 8'h01);
      rd(8'h0b, 4'b0101, d);
      chk("flags same cycle", 64'h01, {56'h0, d});
      chk_rd(8'h0b, 8'h51);
      chk_rd(8'h0b, 8'h01);
      $display("flag test done");
      wr(8'h09, 8'hc8);
      wr(8'h0a, 8'h00);
      dac_ready = 1'b1;
      h_run = 1'b1;
      repeat (600) @(negedge clk);
      dac_ready = 1'b0;
      repeat (500) @(negedge clk);
      h_run = 1'b0;
      repeat (300) @(negedge clk);
      chk_rd(8'h0b, 8'h31);
      chk("buf ready", 64'd0, 64'(dac_buf_ready));
      for (i = 0; i < 2; i++) begin
         chk("dac valid", 64'd1, 64'(dac_valid));
         chk("dac pair", 64'h0000_1234_0000_abcd, dac_pair);
         @(negedge clk) dac_ready = 1'b1;
         @(negedge clk) dac_ready = 1'b0;
      end
      chk("dac valid", 64'd0, 64'(dac_valid));
      $display("slave receive test done");
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      wr(8'h08, 8'hc0);
      for (i = 0; i < 5; i++) begin
         wr(8'h09, cfg[i]);
         frame_len(n, q);
         frame_len(n, q);
         chk("bclk per frame", 64'(len[i]), 64'(n));
         if (i == 0) chk("dout frame", 64'h5a5a_c3c3, {32'h0, q});
         chk("dout enable", 64'd0, 64'(dout_oe_n));
      end
      $display("master frame test done");
      wr(8'h09, 8'hc7);
      frame_len(n, q);
      frame_len(n, q);
      pulse(10);
      chk("resync first", 64'd0, 64'(conv_resync));
      pulse(255);
      chk("resync steady", 64'd0, 64'(conv_resync));
      pulse(383);
      chk("resync drift", 64'd3, 64'(conv_resync));
      repeat (`ASP_MUTE_CYC - 1) @(negedge clk);
      chk("mute held", 64'd3, 64'(conv_mute));
      @(negedge clk);
      chk("mute ended", 64'd0, 64'(conv_mute));
      wr(8'h09, 8'hc2);
      pulse(341);
      chk("resync adc only", 64'd2, 64'(conv_resync));
      chk("resync no mute", 64'd0, 64'(conv_mute));
      $display("resync test done");
      complete_run();
   end
endmodule // audio_serial_port_config_bench
